// ===== include/gsc_pkg.sv
/*
 package for the guest state cache reload selector: register offsets,
 reuse mask bit layout, state group count and sizes.
 assumes a single core clock domain.
*/
package gsc_pkg;
   // register map, byte offsets of 32-bit words on the plain register port
   localparam logic [7:0] reuse_mask_offset = 8'hc0;  // guest_state_reuse_mask
   localparam logic [7:0] block_addr_lo_offset = 8'h00;
   localparam logic [7:0] block_addr_hi_offset = 8'h04;
   localparam logic [7:0] launch_ctrl_offset = 8'h08;
   localparam logic [7:0] reload_status_offset = 8'h0c;
   localparam logic [7:0] hit_status_offset = 8'h10;
   localparam logic [7:0] cache_ctrl_offset = 8'h14;

   localparam int group_count = 12;
   localparam int addr_width = 52;
   localparam int entry_count = 4;
   localparam logic [31:0] mask_reset = 32'h0000_0000;

   // reuse mask bit positions
   localparam int intercept_reuse = 0;
   localparam int permission_map_reuse = 1;
   localparam int asid_reuse = 2;
   localparam int virtual_priority_reuse = 3;
   localparam int nested_paging_reuse = 4;
   localparam int paging_control_reuse = 5;
   localparam int debug_register_reuse = 6;
   localparam int descriptor_table_reuse = 7;
   localparam int segment_state_reuse = 8;
   localparam int fault_address_reuse = 9;
   localparam int branch_record_reuse = 10;
   localparam int virtual_intc_reuse = 11;

   // launch_ctrl bits
   localparam int launch_bit = 0;
   localparam int exit_bit = 1;
   localparam int guest_write_bit = 2;
   // cache_ctrl bits
   localparam int hint_ignore_lsb = 0;
   localparam int invalidate_bit = 31;
endpackage : gsc_pkg

// ===== include/gsc_tag_if.sv
/*
 interface carrying the tag lookup between the selector and its tag store.
 assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
interface gsc_tag_if #(parameter int AW = 52);
   logic [AW-1:0] lookup_addr;
   logic          hit;
   logic          record;
   logic [AW-1:0] record_addr;
   logic          flush;
   modport owner (output lookup_addr, output record, output record_addr, output flush, input hit);
   modport store (input lookup_addr, input record, input record_addr, input flush, output hit);
endinterface : gsc_tag_if

// ===== verilog/gsc_tag_store.sv
/*
 tag store: physical addresses of control blocks whose state is cached.
 assumes record and flush come from the selector, one cycle each.
*/
`timescale 1ns/1ps
module gsc_tag_store
   import gsc_pkg::*;
#(
   parameter int ENTRIES = entry_count,
   parameter int AW      = addr_width
)(
   input wire logic clock,
   input wire logic rst_b,
   gsc_tag_if.store tag
);
   logic [AW-1:0] addr_q [ENTRIES];
   logic [ENTRIES-1:0] valid_q;
   logic [$clog2(ENTRIES)-1:0] victim_q;
   logic [ENTRIES-1:0] match;

   // address only, never the space identifier
   for (genvar i = 0; i < ENTRIES; i++) begin : g_cmp
      assign match[i] = valid_q[i] && (addr_q[i] == tag.lookup_addr);
   end
   assign tag.hit = |match;

   // round robin replacement; an existing copy of the tag is invalidated and the tag is written at the victim slot
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         valid_q  <= '0;
         victim_q <= '0;
         for (int i = 0; i < ENTRIES; i++) begin
            addr_q[i] <= '0;
         end
      end else if (tag.flush) begin
         valid_q <= '0;
      end else if (tag.record) begin
         for (int i = 0; i < ENTRIES; i++) begin
            if (valid_q[i] && addr_q[i] == tag.record_addr) begin
               valid_q[i] <= 1'b0;
            end
         end
         addr_q[victim_q]  <= tag.record_addr;
         valid_q[victim_q] <= 1'b1;
         victim_q          <= victim_q + 1'b1;
      end
   end
endmodule : gsc_tag_store

// ===== verilog/gsc_reload_select.sv
/*
 guest state cache reload selector: per launch, decides for each state group
 whether it is reloaded from the control block or reused from cache.
 assumes the register port master of the house bus; one core clock.
*/
`timescale 1ns/1ps
module gsc_reload_select
   import gsc_pkg::*;
#(
   parameter int GROUPS = group_count,
   parameter int AW     = addr_width
)(
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic      [31:0] reg_rdata,
   output logic [GROUPS-1:0] reload_groups,
   output logic             reload_fixed,
   output logic             reload_valid
);
   logic [31:0]       reuse_mask_q;
   logic [AW-1:0]     block_addr_q;
   logic [GROUPS-1:0] hint_ignore_q;
   logic [GROUPS-1:0] reload_q;
   logic              hit_q;
   logic              dirty_q;
   logic              launch_q;
   logic [31:0]       rdata_q;
   logic              fixed_q;
   logic              write_launch;
   logic              write_exit;
   logic [GROUPS-1:0] reload_d;

   gsc_tag_if #(.AW(AW)) tag ();

   gsc_tag_store #(.ENTRIES(entry_count), .AW(AW)) u_tags (
      .clock (clock),
      .rst_b (rst_b),
      .tag   (tag)
   );

   function automatic logic hit_word(input logic [7:0] a, input logic [7:0] off);
      hit_word = (a == off);
   endfunction : hit_word

   assign write_launch = reg_write && hit_word(reg_addr, launch_ctrl_offset) && reg_wdata[launch_bit];
   assign write_exit   = reg_write && hit_word(reg_addr, launch_ctrl_offset) && reg_wdata[exit_bit];

   assign tag.lookup_addr = block_addr_q;
   assign tag.record      = write_exit;
   assign tag.record_addr = block_addr_q;
   assign tag.flush       = reg_write && hit_word(reg_addr, cache_ctrl_offset) && reg_wdata[invalidate_bit];

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         reuse_mask_q <= mask_reset;
      end else if (reg_write && hit_word(reg_addr, reuse_mask_offset)) begin
         reuse_mask_q <= reg_wdata;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         block_addr_q  <= '0;
         hint_ignore_q <= '0;
      end else if (reg_write) begin
         if (hit_word(reg_addr, block_addr_lo_offset)) begin
            block_addr_q[31:0] <= reg_wdata;
         end
         if (hit_word(reg_addr, block_addr_hi_offset)) begin
            block_addr_q[AW-1:32] <= reg_wdata[AW-33:0];
         end
         if (hit_word(reg_addr, cache_ctrl_offset)) begin
            hint_ignore_q <= reg_wdata[GROUPS-1:0];
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         dirty_q <= 1'b0;
      end else if (reg_write && hit_word(reg_addr, launch_ctrl_offset) && reg_wdata[guest_write_bit]) begin
         // set wins over the launch clear in one write
         dirty_q <= 1'b1;
      end else if (write_launch) begin
         dirty_q <= 1'b0;
      end
   end

   // groups bits 0..11 map to mask bits in order
   always_comb begin
      reload_d = '1;
      for (int g = 0; g < GROUPS; g++) begin
         // miss or clear bit reloads; ignore hint
         reload_d[g] = !(tag.hit && reuse_mask_q[g] && !hint_ignore_q[g]);
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         reload_q <= '1;
         hit_q    <= 1'b0;
         fixed_q  <= 1'b0;
         launch_q <= 1'b0;
      end else begin
         launch_q <= write_launch;
         fixed_q  <= write_launch;
         if (write_launch) begin
            reload_q <= reload_d;
            hit_q    <= tag.hit;
         end
      end
   end

   assign reload_groups = reload_q;
   assign reload_fixed  = fixed_q;
   assign reload_valid  = launch_q;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= '0;
      end else if (reg_read) begin
         unique case (reg_addr)
            reuse_mask_offset:    rdata_q <= reuse_mask_q;
            block_addr_lo_offset: rdata_q <= block_addr_q[31:0];
            block_addr_hi_offset: rdata_q <= {{(64-AW){1'b0}}, block_addr_q[AW-1:32]};
            reload_status_offset: rdata_q <= {{(32-GROUPS){1'b0}}, reload_q};
            hit_status_offset:    rdata_q <= {30'h0, dirty_q, hit_q};
            cache_ctrl_offset:    rdata_q <= {{(32-GROUPS){1'b0}}, hint_ignore_q};
            default:              rdata_q <= 32'h0000_0000;
         endcase
      end else begin
         rdata_q <= 32'h0000_0000;
      end
   end
   assign reg_rdata = rdata_q;

   property p_clear_reloads;
      @(posedge clock) disable iff (!rst_b)
      write_launch |=> (reload_q | $past(tag.hit ? reuse_mask_q[GROUPS-1:0] : '0)) == '1;
   endproperty
   a_clear_reloads: assert property (p_clear_reloads) else $error("clear bit not reloaded");

   property p_miss_all;
      @(posedge clock) disable iff (!rst_b)
      (write_launch && !tag.hit) |=> reload_q == '1;
   endproperty
   a_miss_all: assert property (p_miss_all) else $error("miss did not reload all");

   property p_hit_reuse;
      @(posedge clock) disable iff (!rst_b)
      (write_launch && tag.hit && reuse_mask_q[0] && !hint_ignore_q[0]) |=> !reload_q[0];
   endproperty
   a_hit_reuse: assert property (p_hit_reuse) else $error("clean group 0 reloaded");

   property p_ignore;
      @(posedge clock) disable iff (!rst_b)
      (write_launch && hint_ignore_q[4]) |=> reload_q[4];
   endproperty
   a_ignore: assert property (p_ignore) else $error("ignored hint not reloaded");

   // back to back launches keep the pulses up
   sequence s_launch_pulse;
      reload_fixed && reload_valid ##1 (reload_fixed == $past(write_launch));
   endsequence

   property p_fixed;
      @(posedge clock) disable iff (!rst_b)
      write_launch |=> s_launch_pulse;
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed reload missing");

   property p_record;
      @(posedge clock) disable iff (!rst_b)
      (write_exit && !tag.flush) ##1 (block_addr_q == $past(block_addr_q)) |-> tag.hit;
   endproperty
   a_record: assert property (p_record) else $error("exit tag not recorded");

   property p_mask_store;
      @(posedge clock) disable iff (!rst_b)
      (reg_write && reg_addr == reuse_mask_offset) |=> reuse_mask_q == $past(reg_wdata);
   endproperty
   a_mask_store: assert property (p_mask_store) else $error("mask write lost");

   property p_reserved;
      @(posedge clock) disable iff (!rst_b)
      (reg_write && reg_addr == reuse_mask_offset) |=> reuse_mask_q[31:12] == $past(reg_wdata[31:12]);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved mask bits altered");

   for (genvar g = 0; g < GROUPS; g++) begin : g_group_chk
      property p_group_reuse;
         @(posedge clock) disable iff (!rst_b)
         (write_launch && tag.hit && reuse_mask_q[g] && !hint_ignore_q[g]) |=> !reload_q[g];
      endproperty
      a_group_reuse: assert property (p_group_reuse) else $error("clean group reloaded");

      property p_group_clear;
         @(posedge clock) disable iff (!rst_b)
         (write_launch && !reuse_mask_q[g]) |=> reload_q[g];
      endproperty
      a_group_clear: assert property (p_group_clear) else $error("clear group reused");
   end

   property p_hold_groups;
      @(posedge clock) disable iff (!rst_b)
      !write_launch |=> $stable(reload_q);
   endproperty
   a_hold_groups: assert property (p_hold_groups) else $error("reload flags moved without launch");

   property p_rdata_idle;
      @(posedge clock) disable iff (!rst_b)
      !reg_read |=> reg_rdata == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");

   property p_read_mask;
      @(posedge clock) disable iff (!rst_b)
      (reg_read && reg_addr == reuse_mask_offset) |=> reg_rdata == $past(reuse_mask_q);
   endproperty
   a_read_mask: assert property (p_read_mask) else $error("mask read back wrong");

   property p_flush_miss;
      @(posedge clock) disable iff (!rst_b)
      tag.flush |=> !tag.hit;
   endproperty
   a_flush_miss: assert property (p_flush_miss) else $error("hit after flush");

   property p_guest_keep;
      @(posedge clock) disable iff (!rst_b)
      (reg_write && reg_addr == launch_ctrl_offset && reg_wdata[guest_write_bit] && !reg_wdata[exit_bit])
         |=> tag.hit == $past(tag.hit);
   endproperty
   a_guest_keep: assert property (p_guest_keep) else $error("guest update changed cache hit");

   property p_pulse_pair;
      @(posedge clock) disable iff (!rst_b)
      reload_valid == reload_fixed;
   endproperty
   a_pulse_pair: assert property (p_pulse_pair) else $error("valid and fixed pulses differ");

   property p_valid_cause;
      @(posedge clock) disable iff (!rst_b)
      reload_valid |-> $past(write_launch);
   endproperty
   a_valid_cause: assert property (p_valid_cause) else $error("valid pulse without launch");

   property p_read_groups;
      @(posedge clock) disable iff (!rst_b)
      (reg_read && reg_addr == reload_status_offset) |=> reg_rdata[GROUPS-1:0] == $past(reload_q);
   endproperty
   a_read_groups: assert property (p_read_groups) else $error("reload status read wrong");

   property p_hint_store;
      @(posedge clock) disable iff (!rst_b)
      (reg_write && reg_addr == cache_ctrl_offset) |=> hint_ignore_q == $past(reg_wdata[GROUPS-1:0]);
   endproperty
   a_hint_store: assert property (p_hint_store) else $error("hint ignore write lost");

   property p_hit_latch;
      @(posedge clock) disable iff (!rst_b)
      write_launch |=> hit_q == $past(tag.hit);
   endproperty
   a_hit_latch: assert property (p_hit_latch) else $error("launch hit not latched");

   property p_dirty_set;
      @(posedge clock) disable iff (!rst_b)
      (reg_write && reg_addr == launch_ctrl_offset && reg_wdata[guest_write_bit]) |=> dirty_q;
   endproperty
   a_dirty_set: assert property (p_dirty_set) else $error("guest update not noted");

   property p_mask_keep;
      @(posedge clock) disable iff (!rst_b)
      !(reg_write && reg_addr == reuse_mask_offset) |=> $stable(reuse_mask_q);
   endproperty
   a_mask_keep: assert property (p_mask_keep) else $error("mask changed without write");

   property p_addr_keep;
      @(posedge clock) disable iff (!rst_b)
      !reg_write |=> $stable(block_addr_q);
   endproperty
   a_addr_keep: assert property (p_addr_keep) else $error("block address changed without write");
endmodule : gsc_reload_select

// ===== verif/hyp_model.sv
/*
 hypervisor model: register port master and reuse mask policy.
 assumes the selector's plain register port on one clock.
*/
`timescale 1ns/1ps
module hyp_model (
   input  wire logic        clock,
   output logic      [7:0]  reg_addr,
   output logic      [31:0] reg_wdata,
   output logic             reg_write,
   output logic             reg_read,
   input  wire logic [31:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      reg_write = 1'b0;
      reg_read = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask : wr
   // data only stands one cycle, so sample just after the edge
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd
   function automatic logic [31:0] mask_for(input logic fresh, input logic [11:0] edited);
      if (fresh) return 32'h0000_0000;
      if (edited == 12'h000) return 32'hffff_ffff;
      return {20'h00000, ~edited};
   endfunction : mask_for
endmodule : hyp_model

// ===== verif/gsc_reload_select_tb.sv
/*
 testbench for the reload selector, with a tag and mask model.
 assumes hyp_model drives the register port.
*/
`timescale 1ns/1ps
module gsc_reload_select_tb;
   import gsc_pkg::*;
   logic        clock = 1'b0;
   logic        rst_b = 1'b0;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rv, seed = 32'hf957;
   logic        reg_write, reg_read, reload_fixed, reload_valid;
   logic [11:0] reload_groups, ign = 12'h000;
   logic [51:0] tags[$], a0, b;
   int          miscompares = 0, n_compared = 0;
   always #2 clock = ~clock;
   hyp_model u_hyp_model (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
   gsc_reload_select u_gsc_reload_select (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .reload_groups(reload_groups), .reload_fixed(reload_fixed), .reload_valid(reload_valid));
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   task automatic bad(string n, logic [31:0] e, logic [31:0] g);
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      miscompares++;
   endtask : bad
   task automatic chk_reg(logic [7:0] a, logic [31:0] e);
      u_hyp_model.rd(a, rv);
      n_compared++;
      if (rv !== e) bad("reg_rdata", e, rv);
   endtask : chk_reg
   task automatic chk_out(logic [11:0] g, logic p);
      n_compared++;
      if ({reload_groups, reload_fixed, reload_valid} !== {g, p, p})
         bad("reload_out", {g, p, p}, {reload_groups, reload_fixed, reload_valid});
   endtask : chk_out
   task automatic stop_test();
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test
   task automatic put(logic [51:0] a, logic [31:0] m);
      u_hyp_model.wr(block_addr_lo_offset, a[31:0]);
      u_hyp_model.wr(block_addr_hi_offset, {12'h000, a[51:32]});
      u_hyp_model.wr(reuse_mask_offset, m);
   endtask : put
   // groups reload unless tag hit, bit set and not ignored
   task automatic launch(logic [51:0] a, logic [31:0] m);
      logic        hit;
      logic [11:0] e;
      hit = 1'b0;
      foreach (tags[i]) if (tags[i] === a) hit = 1'b1;
      e = ~(hit ? m[11:0] & ~ign : 12'h000);
      put(a, m);
      u_hyp_model.wr(launch_ctrl_offset, 32'h1);
      #1;
      chk_out(e, 1'b1);
      @(posedge clock);
      #1;
      chk_out(e, 1'b0);
      chk_reg(reload_status_offset, {20'h00000, e});
   endtask : launch
   // four entries, oldest evicted first
   task automatic leave(logic [51:0] a);
      put(a, 32'h0);
      u_hyp_model.wr(launch_ctrl_offset, 32'h2);
      tags.push_back(a);
      if (tags.size() > entry_count) void'(tags.pop_front());
   endtask : leave
   initial begin
      repeat (100000) @(posedge clock);
      miscompares++;
      stop_test();
   end
   initial begin
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      #1;
      chk_out(12'hfff, 1'b0);
      chk_reg(reuse_mask_offset, mask_reset);
      chk_reg(8'hfc, 32'h0);
      $display("test reset done");
      a0 = 52'({xs(), xs()});
      launch(a0, 32'hffff_ffff);
      leave(a0);
      launch(a0, u_hyp_model.mask_for(1'b0, 12'h000));
      chk_reg(block_addr_lo_offset, a0[31:0]);
      chk_reg(block_addr_hi_offset, {12'h000, a0[51:32]});
      u_hyp_model.wr(reuse_mask_offset, 32'h5a5a_a5a5);
      chk_reg(reuse_mask_offset, 32'h5a5a_a5a5);
      $display("test hit done");
      // one edited group at a time walks the bit layout
      for (int i = 0; i < group_count; i++)
         launch(a0, u_hyp_model.mask_for(1'b0, 12'(1 << i)));
      launch(a0, u_hyp_model.mask_for(1'b1, 12'h000));
      $display("test groups done");
      // bit 4 forced so the ignore check always has work
      ign = 12'(xs()) | 12'h010;
      u_hyp_model.wr(cache_ctrl_offset, {20'h00000, ign});
      chk_reg(cache_ctrl_offset, {20'h00000, ign});
      launch(a0, 32'hffff_ffff);
      ign = 12'h000;
      u_hyp_model.wr(cache_ctrl_offset, 32'h0);
      u_hyp_model.wr(launch_ctrl_offset, 32'h4);
      chk_reg(hit_status_offset, 32'h0000_0003);
      launch(a0, 32'hffff_ffff);
      chk_reg(hit_status_offset, 32'h0000_0001);
      b = a0 ^ 52'h8_0000_0000_0000;
      launch(b, 32'hffff_ffff);
      $display("test hint done");
      for (int i = 0; i < 5; i++) leave(52'({xs(), xs()}));
      launch(a0, 32'hffff_ffff);
      for (int i = 0; i < 8; i++)
         launch(tags[xs() % tags.size()], u_hyp_model.mask_for(1'b0, 12'(xs())));
      u_hyp_model.wr(cache_ctrl_offset, 32'h8000_0000);
      tags.delete();
      launch(a0, 32'hffff_ffff);
      $display("test evict done");
      stop_test();
   end
endmodule : gsc_reload_select_tb
